// ==== logic/amd_pkg.sv ====
// Package for the addressing-mode decoder: prefixes, modes, lengths and carriers
package amd_pkg;

	// Prefix byte codes
	localparam logic [7:0] AMD_Y_SELECT_PREFIX      = 8'h90;
	localparam logic [7:0] AMD_INDIRECT_Y_PREFIX    = 8'h91;
	localparam logic [7:0] AMD_INDIRECT_SELECT_PREFIX = 8'h92;

	// Reset values
	localparam logic [15:0] AMD_ADDR_RST = 16'h0000;
	localparam logic [7:0]  AMD_BYTE_RST = 8'h00;
	localparam logic [7:0]  AMD_PAGE0_HI = 8'h00;

	// Operand byte counts beyond the opcode
	localparam logic [1:0] AMD_LEN_0 = 2'd0;
	localparam logic [1:0] AMD_LEN_1 = 2'd1;
	localparam logic [1:0] AMD_LEN_2 = 2'd2;

	// Mode requested by the opcode decoder (before prefix conversion)
	typedef enum logic [3:0] {
		AMD_M_INHERENT,
		AMD_M_IMMEDIATE,
		AMD_M_DIRECT_SHORT,
		AMD_M_DIRECT_LONG,
		AMD_M_IDX_NONE,
		AMD_M_IDX_SHORT,
		AMD_M_IDX_LONG,
		AMD_M_IND_SHORT,
		AMD_M_IND_LONG,
		AMD_M_IIDX_SHORT,
		AMD_M_IIDX_LONG,
		AMD_M_REL_DIRECT,
		AMD_M_BIT_DIRECT,
		AMD_M_BIT_REL
	} amd_mode_t;

	// Decode request from the core
	typedef struct packed {
		amd_mode_t   mode;
		logic [7:0]  prefix;
		logic        has_prefix;
		logic        rmw;
		logic [15:0] pc_next;
		logic [7:0]  idx_x;
		logic [7:0]  idx_y;
	} amd_req_t;

	// Decode answer to the core
	typedef struct packed {
		logic        ok;
		logic        illegal_long_rmw;
		logic        use_y;
		logic        indirect;
		logic        is_imm;
		logic [7:0]  imm;
		logic [2:0]  length;
		logic [15:0] ea;
		logic [15:0] branch_target;
	} amd_rsp_t;

endpackage : amd_pkg

// ==== logic/amd_addressing_mode_decoder.sv ====
// Addressing-mode decoder with effective-address and branch-target generation
`timescale 1ns/1ps
// Function
// - Inherent instruction is one byte only
// - Immediate uses one operand byte as value
// - Short direct: one address byte, page zero
// - Long direct: two address bytes, full space
// - Indexed address is index plus offset, unsigned
// - No-offset indexed uses index alone
// - No-offset length: zero with X, one with Y
// - Short indexed: byte offset, up to 1FE
// - Long indexed: word offset, full space
// - Short indirect: byte pointer gives page-zero address
// - Long indirect: word pointer gives full address
// - Short direct and short indirect reach page zero only; short indexed reaches up to 1FE
// - Read-modify-write refuses only the long forms; short and no-offset forms are allowed
// - Branch adds signed offset to next PC
// - Y-select prefix swaps X for Y
// - Indirect-select prefix makes direct and short/long indexed forms indirect
// - Indirect-Y prefix swaps X for Y in indirect indexed
module amd_addressing_mode_decoder (
	// Clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_rstn,
	// Decode request
	input  wire logic              i_start,
	input  amd_pkg::amd_req_t      i_req,
	// Memory read port (one byte per request, answer in the same cycle)
	output logic                   o_mem_rd,
	output logic [15:0]            o_mem_addr,
	input  wire logic [7:0]        i_mem_data,
	// Decode answer
	output logic                   o_busy,
	output logic                   o_done,
	output amd_pkg::amd_rsp_t      o_rsp
);
	import amd_pkg::*;

	typedef enum {
		AMD_IDLE,
		AMD_FETCH_OP,
		AMD_FETCH_PTR,
		AMD_FINISH
	} amd_state_t;

	amd_state_t   state_reg;
	amd_req_t     req_reg;
	amd_mode_t    mode_reg;
	logic         use_y_reg;
	logic         indirect_reg;
	logic [1:0]   op_cnt_reg;
	logic [1:0]   op_idx_reg;
	logic [15:0]  op_word_reg;
	logic [1:0]   ptr_cnt_reg;
	logic [1:0]   ptr_idx_reg;
	logic [15:0]  ptr_word_reg;
	logic [15:0]  fetch_pc_reg;
	logic         wait_reg;

	// Prefix conversion of the requested mode, done once at start
	amd_mode_t    mode_next;
	logic         use_y_next;
	logic         ind_next;
	logic [1:0]   op_cnt_next;
	logic         op_len_extra;

	always_comb begin
		mode_next  = i_req.mode;
		use_y_next = 1'b0;
		ind_next   = 1'b0;
		if (i_req.has_prefix && i_req.prefix == AMD_Y_SELECT_PREFIX) begin
			use_y_next = 1'b1;
		end else if (i_req.has_prefix && i_req.prefix == AMD_INDIRECT_SELECT_PREFIX) begin
			ind_next = 1'b1;
			case (i_req.mode)
				AMD_M_DIRECT_SHORT: mode_next = AMD_M_IND_SHORT;
				AMD_M_DIRECT_LONG:  mode_next = AMD_M_IND_LONG;
				AMD_M_IDX_SHORT:    mode_next = AMD_M_IIDX_SHORT;
				AMD_M_IDX_LONG:     mode_next = AMD_M_IIDX_LONG;
				default:            mode_next = i_req.mode;
			endcase
		end else if (i_req.has_prefix && i_req.prefix == AMD_INDIRECT_Y_PREFIX) begin
			ind_next   = 1'b1;
			use_y_next = 1'b1;
			case (i_req.mode)
				AMD_M_IDX_SHORT: mode_next = AMD_M_IIDX_SHORT;
				AMD_M_IDX_LONG:  mode_next = AMD_M_IIDX_LONG;
				default:         mode_next = i_req.mode;
			endcase
		end
		case (mode_next)
			AMD_M_INHERENT:    op_cnt_next = AMD_LEN_0;
			AMD_M_IDX_NONE:    op_cnt_next = AMD_LEN_0;
			AMD_M_DIRECT_LONG: op_cnt_next = AMD_LEN_2;
			AMD_M_IDX_LONG:    op_cnt_next = AMD_LEN_2;
			AMD_M_BIT_REL:     op_cnt_next = AMD_LEN_2;
			default:           op_cnt_next = AMD_LEN_1;
		endcase
	end

	// Prefix byte counts in the length; gives +1 for no-offset indexed with Y
	assign op_len_extra = req_reg.has_prefix;

	// Pointer fetch size after the pointer address byte
	logic [1:0] ptr_cnt_next;
	always_comb begin
		case (mode_next)
			AMD_M_IND_LONG:  ptr_cnt_next = AMD_LEN_2;
			AMD_M_IIDX_LONG: ptr_cnt_next = AMD_LEN_2;
			AMD_M_IND_SHORT: ptr_cnt_next = AMD_LEN_1;
			AMD_M_IIDX_SHORT: ptr_cnt_next = AMD_LEN_1;
			default:         ptr_cnt_next = ind_next ? AMD_LEN_1 : AMD_LEN_0;
		endcase
	end

	// Sequencing of operand and pointer fetches
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_reg    <= AMD_IDLE;
			op_idx_reg   <= AMD_LEN_0;
			ptr_idx_reg  <= AMD_LEN_0;
			wait_reg     <= 1'b0;
			fetch_pc_reg <= AMD_ADDR_RST;
		end else begin
			case (state_reg)
				AMD_IDLE: begin
					if (i_start) begin
						op_idx_reg   <= AMD_LEN_0;
						ptr_idx_reg  <= AMD_LEN_0;
						wait_reg     <= 1'b0;
						fetch_pc_reg <= i_req.pc_next;
						state_reg    <= (op_cnt_next == AMD_LEN_0) ? AMD_FINISH : AMD_FETCH_OP;
					end
				end
				AMD_FETCH_OP: begin
					if (wait_reg) begin
						wait_reg     <= 1'b0;
						op_idx_reg   <= op_idx_reg + 2'd1;
						fetch_pc_reg <= fetch_pc_reg + 16'h0001;
						if (op_idx_reg + 2'd1 == op_cnt_reg)
							state_reg <= (ptr_cnt_reg != AMD_LEN_0) ? AMD_FETCH_PTR : AMD_FINISH;
					end else begin
						wait_reg <= 1'b1;
					end
				end
				AMD_FETCH_PTR: begin
					if (wait_reg) begin
						wait_reg    <= 1'b0;
						ptr_idx_reg <= ptr_idx_reg + 2'd1;
						if (ptr_idx_reg + 2'd1 == ptr_cnt_reg)
							state_reg <= AMD_FINISH;
					end else begin
						wait_reg <= 1'b1;
					end
				end
				AMD_FINISH: state_reg <= AMD_IDLE;
				default:    state_reg <= AMD_IDLE;
			endcase
		end
	end

	// Request capture
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			req_reg      <= '0;
			mode_reg     <= AMD_M_INHERENT;
			use_y_reg    <= 1'b0;
			indirect_reg <= 1'b0;
			op_cnt_reg   <= AMD_LEN_0;
			ptr_cnt_reg  <= AMD_LEN_0;
		end else if (state_reg == AMD_IDLE && i_start) begin
			req_reg      <= i_req;
			mode_reg     <= mode_next;
			use_y_reg    <= use_y_next;
			indirect_reg <= ind_next;
			op_cnt_reg   <= op_cnt_next;
			ptr_cnt_reg  <= ptr_cnt_next;
		end
	end

	// Operand bytes arrive high byte first; pointer word likewise
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			op_word_reg  <= AMD_ADDR_RST;
			ptr_word_reg <= AMD_ADDR_RST;
		end else if (state_reg == AMD_IDLE && i_start) begin
			op_word_reg  <= AMD_ADDR_RST;
			ptr_word_reg <= AMD_ADDR_RST;
		end else if (wait_reg && state_reg == AMD_FETCH_OP) begin
			op_word_reg <= {op_word_reg[7:0], i_mem_data};
		end else if (wait_reg && state_reg == AMD_FETCH_PTR) begin
			ptr_word_reg <= {ptr_word_reg[7:0], i_mem_data};
		end
	end

	// Pointer bytes are read from the pointer address in page zero and the byte after it, carrying into 0100 from ff
	// Bit-relative keeps its bit address first and its branch offset second, so the
	// pointer address is the first operand byte there and the last one everywhere else
	logic [7:0]  ptr_base;
	logic [15:0] ptr_addr;
	always_comb begin
		if (mode_reg == AMD_M_BIT_REL) begin
			ptr_base = op_word_reg[15:8];
		end else begin
			ptr_base = op_word_reg[7:0];
		end
	end
	assign ptr_addr = {AMD_PAGE0_HI, ptr_base} + {14'h0000, ptr_idx_reg};

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_mem_rd   <= 1'b0;
			o_mem_addr <= AMD_ADDR_RST;
		end else begin
			o_mem_rd   <= 1'b0;
			if (state_reg == AMD_FETCH_OP && !wait_reg) begin
				o_mem_rd   <= 1'b1;
				o_mem_addr <= fetch_pc_reg;
			end else if (state_reg == AMD_FETCH_PTR && !wait_reg) begin
				o_mem_rd   <= 1'b1;
				o_mem_addr <= ptr_addr;
			end
		end
	end

	// Effective address and branch target
	logic [7:0]  index;
	logic [15:0] ea;
	logic [15:0] rel_base;
	logic [15:0] target;
	logic [2:0]  length;
	logic        bad_rmw;

	// Index choice follows the prefix; register values are those sampled with the start
	assign index = use_y_reg ? req_reg.idx_y : req_reg.idx_x;

	always_comb begin
		ea = AMD_ADDR_RST;
		// Indirect bit forms take the pointed byte as their page-zero bit address
		case (mode_reg)
			AMD_M_DIRECT_SHORT: ea = {AMD_PAGE0_HI, op_word_reg[7:0]};
			AMD_M_BIT_DIRECT:   ea = {AMD_PAGE0_HI, indirect_reg ? ptr_word_reg[7:0] : op_word_reg[7:0]};
			AMD_M_BIT_REL:      ea = {AMD_PAGE0_HI, indirect_reg ? ptr_word_reg[7:0] : op_word_reg[15:8]};
			AMD_M_DIRECT_LONG:  ea = op_word_reg;
			AMD_M_IDX_NONE:     ea = {AMD_PAGE0_HI, index};
			AMD_M_IDX_SHORT:    ea = {AMD_PAGE0_HI, index} + {AMD_PAGE0_HI, op_word_reg[7:0]};
			AMD_M_IDX_LONG:     ea = {AMD_PAGE0_HI, index} + op_word_reg;
			AMD_M_IND_SHORT:    ea = {AMD_PAGE0_HI, ptr_word_reg[7:0]};
			AMD_M_IND_LONG:     ea = ptr_word_reg;
			AMD_M_IIDX_SHORT:   ea = {AMD_PAGE0_HI, index} + {AMD_PAGE0_HI, ptr_word_reg[7:0]};
			AMD_M_IIDX_LONG:    ea = {AMD_PAGE0_HI, index} + ptr_word_reg;
			default:            ea = AMD_ADDR_RST;
		endcase
	end

	// Relative offset: operand byte, or the pointed byte when indirect; the indirect
	// bit-relative form points only at its bit address and keeps the offset inline
	logic [7:0] rel_off;
	always_comb begin
		if (indirect_reg && mode_reg != AMD_M_BIT_REL) begin
			rel_off = ptr_word_reg[7:0];
		end else begin
			rel_off = op_word_reg[7:0];
		end
	end
	// The prefix stands before the opcode, so it does not move the next-instruction PC:
	// only the operand bytes after pc_next are skipped
	assign rel_base = req_reg.pc_next + {14'h0000, op_cnt_reg};
	assign target   = rel_base + {{8{rel_off[7]}}, rel_off};

	// Long forms are refused for memory read-modify-write
	assign bad_rmw = req_reg.rmw && (mode_reg == AMD_M_DIRECT_LONG || mode_reg == AMD_M_IDX_LONG
		|| mode_reg == AMD_M_IND_LONG || mode_reg == AMD_M_IIDX_LONG);

	// Length counted from the opcode: operand bytes plus any prefix byte
	assign length = {1'b0, op_cnt_reg} + {2'b00, op_len_extra};

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_done <= 1'b0;
			o_busy <= 1'b0;
			o_rsp  <= '0;
		end else begin
			// A start while busy is dropped without notice; the core waits for done
			o_done <= (state_reg == AMD_FINISH);
			o_busy <= (state_reg != AMD_IDLE) || i_start;
			if (state_reg == AMD_FINISH) begin
				o_rsp.ok               <= !bad_rmw;
				o_rsp.illegal_long_rmw <= bad_rmw;
				o_rsp.use_y            <= use_y_reg;
				o_rsp.indirect         <= indirect_reg;
				o_rsp.is_imm           <= (mode_reg == AMD_M_IMMEDIATE);
				o_rsp.imm              <= (mode_reg == AMD_M_IMMEDIATE) ? op_word_reg[7:0] : AMD_BYTE_RST;
				o_rsp.length           <= length;
				o_rsp.ea               <= ea;
				o_rsp.branch_target    <= target;
			end
		end
	end

endmodule : amd_addressing_mode_decoder

// ==== tb/amd_addressing_mode_decoder_checker.sv ====
// Port-level assertions for the addressing-mode decoder
`timescale 1ns/1ps
module amd_addressing_mode_decoder_checker
	import amd_pkg::*;
(
	// Clock and reset
	input wire logic        i_clk,
	input wire logic        i_rstn,
	// Request and memory
	input wire logic        i_start,
	input amd_req_t         i_req,
	input wire logic        o_mem_rd,
	input wire logic [15:0] o_mem_addr,
	input wire logic [7:0]  i_mem_data,
	// Answer
	input wire logic        o_busy,
	input wire logic        o_done,
	input amd_rsp_t         o_rsp
);
	amd_req_t q_reg;
	// Request as taken, so the answer can be tied to its cause
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			q_reg <= '0;
		end else if (i_start && (!o_busy || o_done)) begin
			q_reg <= i_req;
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	a_inh_len: assert property (o_done && q_reg.mode == AMD_M_INHERENT && !q_reg.has_prefix |->
		o_rsp.length == 3'd0 && o_rsp.ok) else $error("inherent answer wrong");
	a_inh_noread: assert property (o_busy && q_reg.mode == AMD_M_INHERENT |-> !o_mem_rd)
		else $error("inherent decode read memory");
	a_imm_len: assert property (o_done && q_reg.mode == AMD_M_IMMEDIATE && !q_reg.has_prefix |->
		o_rsp.is_imm && o_rsp.length == 3'd1) else $error("immediate answer wrong");
	a_dshort_page: assert property (o_done && q_reg.mode == AMD_M_DIRECT_SHORT && !q_reg.has_prefix |->
		o_rsp.ea[15:8] == 8'h00 && o_rsp.length == 3'd1) else $error("short direct off page zero");
	a_idx_none: assert property (o_done && q_reg.mode == AMD_M_IDX_NONE && !q_reg.has_prefix |->
		o_rsp.ea == {8'h00, q_reg.idx_x} && o_rsp.length == 3'd0) else $error("no-offset index wrong");
	a_idx_short: assert property (o_done && q_reg.mode == AMD_M_IDX_SHORT && !q_reg.has_prefix |->
		o_rsp.ea <= 16'h01fe && o_rsp.ea >= {8'h00, q_reg.idx_x}) else $error("short index out of range");
	a_long_rmw: assert property (o_done && q_reg.rmw && q_reg.mode inside {AMD_M_DIRECT_LONG, AMD_M_IDX_LONG}
		|-> !o_rsp.ok && o_rsp.illegal_long_rmw) else $error("long form accepted for rmw");
	a_first_fetch: assert property ($rose(o_busy) ##1 o_mem_rd |-> o_mem_addr == q_reg.pc_next)
		else $error("first operand not after opcode");
	a_ptr_page: assert property (o_mem_rd && $past(o_mem_rd, 2) && q_reg.mode == AMD_M_IND_SHORT
		&& !q_reg.has_prefix |-> o_mem_addr[15:8] == 8'h00) else $error("pointer read off page zero");
endmodule : amd_addressing_mode_decoder_checker

bind amd_addressing_mode_decoder amd_addressing_mode_decoder_checker u_chk (.i_clk(i_clk), .i_rstn(i_rstn),
	.i_start(i_start), .i_req(i_req), .o_mem_rd(o_mem_rd), .o_mem_addr(o_mem_addr), .i_mem_data(i_mem_data),
	.o_busy(o_busy), .o_done(o_done), .o_rsp(o_rsp));

// ==== tb/amd_mem_model.sv ====
// Byte memory with a combinational read port, answering in the cycle of each read request
`timescale 1ns/1ps
module amd_mem_model (
	input wire logic        i_clk,
	input wire logic        i_rd,
	input wire logic [15:0] i_addr,
	output logic [7:0]      o_data
);
	logic [7:0] idle_q = 8'h00;
	// The decoder samples the byte at the end of its read cycle, so the answer stands at once;
	// outside a read the bus toggles, so a sample out of that cycle shows up as wrong data
	always @(posedge i_clk) begin
		idle_q <= ~idle_q;
	end
	assign o_data = i_rd ? (i_addr[7:0] ^ i_addr[15:8] ^ 8'h3c) : idle_q;
endmodule : amd_mem_model

// ==== tb/amd_addressing_mode_decoder_tb.sv ====
// Self-checking bench for the addressing-mode decoder
`timescale 1ns/1ps
module amd_addressing_mode_decoder_tb;
	import amd_pkg::*;
	logic        i_clk = 1'b0;
	logic        i_rstn = 1'b0;
	logic        i_start = 1'b0;
	amd_req_t    req = '0;
	logic        mem_rd, busy, done;
	logic [15:0] mem_addr;
	logic [7:0]  mem_data;
	amd_rsp_t    rsp;
	int          num_errors = 0;
	int          n_compared = 0;
	// Operand byte here is ff, next one f8; page-zero ff holds c3, 0100 holds 3d
	localparam logic [15:0] pc0 = 16'h10d3;
	always #2.5 i_clk = ~i_clk;
	amd_addressing_mode_decoder uut (.i_clk(i_clk), .i_rstn(i_rstn), .i_start(i_start), .i_req(req),
		.o_mem_rd(mem_rd), .o_mem_addr(mem_addr), .i_mem_data(mem_data), .o_busy(busy), .o_done(done),
		.o_rsp(rsp));
	amd_mem_model u_mem (.i_clk(i_clk), .i_rd(mem_rd), .i_addr(mem_addr), .o_data(mem_data));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic report_and_stop();
		if (num_errors == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : report_and_stop
	task automatic run(input amd_mode_t m, input logic [7:0] p, input logic r);
		int n;
		n = 0;
		@(posedge i_clk);
		req <= '{mode: m, prefix: p, has_prefix: p != 8'h00, rmw: r, pc_next: pc0, idx_x: 8'hff, idx_y: 8'h80};
		i_start <= 1'b1;
		@(posedge i_clk);
		i_start <= 1'b0;
		#1;
		while (done !== 1'b1 && n < 20) begin
			@(posedge i_clk);
			#1;
			n++;
		end
		if (n == 20) num_errors++;
	endtask : run
	task automatic t_simple();
		run(AMD_M_INHERENT, 8'h00, 1'b0);
		chk(rsp.length, 16'h0);
		chk(rsp.ok, 16'h1);
		run(AMD_M_IMMEDIATE, 8'h00, 1'b0);
		chk(rsp.is_imm, 16'h1);
		chk(rsp.imm, 16'hff);
		chk(rsp.length, 16'h1);
	endtask : t_simple
	task automatic t_direct();
		run(AMD_M_DIRECT_SHORT, 8'h00, 1'b0);
		chk(rsp.ea, 16'h00ff);
		run(AMD_M_DIRECT_LONG, 8'h00, 1'b0);
		chk(rsp.ea, 16'hfff8);
		chk(rsp.length, 16'h2);
	endtask : t_direct
	task automatic t_indexed();
		run(AMD_M_IDX_NONE, 8'h00, 1'b0);
		chk(rsp.ea, 16'h00ff);
		chk(rsp.length, 16'h0);
		run(AMD_M_IDX_NONE, AMD_Y_SELECT_PREFIX, 1'b0);
		chk(rsp.ea, 16'h0080);
		chk(rsp.length, 16'h1);
		chk(rsp.use_y, 16'h1);
		run(AMD_M_IDX_SHORT, 8'h00, 1'b0);
		chk(rsp.ea, 16'h01fe);
		run(AMD_M_IDX_LONG, 8'h00, 1'b0);
		chk(rsp.ea, 16'h00f7);
	endtask : t_indexed
	task automatic t_indirect();
		run(AMD_M_IND_SHORT, 8'h00, 1'b0);
		chk(rsp.ea, 16'h00c3);
		run(AMD_M_IND_LONG, 8'h00, 1'b0);
		chk(rsp.ea, 16'hc33d);
		run(AMD_M_DIRECT_SHORT, AMD_INDIRECT_SELECT_PREFIX, 1'b0);
		chk(rsp.ea, 16'h00c3);
		chk(rsp.indirect, 16'h1);
		run(AMD_M_IIDX_SHORT, AMD_INDIRECT_Y_PREFIX, 1'b0);
		chk(rsp.ea, 16'h0143);
		chk(rsp.use_y, 16'h1);
	endtask : t_indirect
	task automatic t_other();
		run(AMD_M_REL_DIRECT, 8'h00, 1'b0);
		chk(rsp.branch_target, 16'h10d3);
		run(AMD_M_DIRECT_LONG, 8'h00, 1'b1);
		chk(rsp.ok, 16'h0);
		chk(rsp.illegal_long_rmw, 16'h1);
		run(AMD_M_DIRECT_SHORT, 8'h00, 1'b1);
		chk(rsp.ok, 16'h1);
		run(AMD_M_REL_DIRECT, AMD_INDIRECT_SELECT_PREFIX, 1'b0);
		chk(rsp.branch_target, 16'h1097);
		chk(rsp.length, 16'h2);
		run(AMD_M_BIT_REL, 8'h00, 1'b0);
		chk(rsp.ea, 16'h00ff);
		chk(rsp.branch_target, 16'h10cd);
		chk(rsp.length, 16'h2);
		run(AMD_M_BIT_REL, AMD_INDIRECT_SELECT_PREFIX, 1'b0);
		chk(rsp.ea, 16'h00c3);
		chk(rsp.branch_target, 16'h10cd);
		chk(rsp.length, 16'h3);
		run(AMD_M_BIT_DIRECT, AMD_INDIRECT_SELECT_PREFIX, 1'b0);
		chk(rsp.ea, 16'h00c3);
		run(AMD_M_IDX_LONG, AMD_INDIRECT_SELECT_PREFIX, 1'b0);
		chk(rsp.ea, 16'hc43c);
	endtask : t_other
	initial begin
		repeat (10) @(posedge i_clk);
		i_rstn <= 1'b1;
		t_simple();
		t_direct();
		t_indexed();
		t_indirect();
		t_other();
		report_and_stop();
	end
	initial begin
		#20000;
		num_errors++;
		report_and_stop();
	end
endmodule : amd_addressing_mode_decoder_tb
